// ===== verilog/iem_ctrl.sv
// Purpose: Interrupt enable mask register and request gating for an 8-bit core
// Assumes: All inputs synchronous to clk; one SFR access port from the CPU
// Notes:   Gated requests and read data are registered, one cycle behind inputs; external pin requests pass the pending flag first, two cycles behind
`timescale 1ns/1ps
`include "iem_defs.svh"

module iem_ctrl #(
  parameter int DATA_W = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [DATA_W-1:0]    sfr_wdata,
  input  wire logic [7:0]           bit_addr,
  input  wire logic                 bit_wr,
  input  wire logic                 bit_wdata,
  input  wire logic                 serial_periph_unit_req,
  input  wire logic                 timer2_low_overflow_flag,
  input  wire logic                 timer2_high_overflow_flag,
  input  wire logic                 async_serial_port_req,
  input  wire logic                 timer1_overflow_flag,
  input  wire logic                 timer0_overflow_flag,
  input  wire logic                 ext_irq_input_0,
  input  wire logic                 ext_irq_input_1,
  input  iem_pkg::iem_ext_cfg_t     ext0_cfg,
  input  iem_pkg::iem_ext_cfg_t     ext1_cfg,
  input  wire logic                 ext0_vector_ack,
  input  wire logic                 ext1_vector_ack,
  output logic [DATA_W-1:0]         sfr_rdata,
  output iem_pkg::iem_req_t         irq_req,
  output logic [1:0]                ext_pending
);
  import iem_pkg::*;

  if (DATA_W != 8) begin : g_width_check
    $error("iem_ctrl serves an 8-bit register only");
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  logic [7:0]   interrupt_enable_mask_reg;
  logic         byte_hit;
  logic         bit_hit;
  logic [2:0]   bit_sel;

  // No page input: this register decodes the same on every page
  assign byte_hit = (sfr_addr == `IEM_SFR_ADDR);
  assign bit_hit  = (bit_addr >= `IEM_BIT_BASE) && (bit_addr <= `IEM_BIT_LAST);
  assign bit_sel  = bit_addr[2:0];

  // A byte write wins over a bit write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_mask_reg <= `IEM_RESET_VALUE;
    end else if (sfr_wr && byte_hit) begin
      interrupt_enable_mask_reg <= sfr_wdata;
    end else if (bit_wr && bit_hit) begin
      interrupt_enable_mask_reg[bit_sel] <= bit_wdata;
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && byte_hit) begin
      sfr_rdata <= interrupt_enable_mask_reg;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // External interrupt pending flags
  // ----------------------------------------------------------------
  logic [1:0] ext_active;
  logic [1:0] prev_active;
  logic [1:0] ext_edge;

  assign ext_active[0] = ext0_cfg.active_high ? ext_irq_input_0 : ~ext_irq_input_0;
  assign ext_active[1] = ext1_cfg.active_high ? ext_irq_input_1 : ~ext_irq_input_1;
  assign ext_edge      = ext_active & ~prev_active;

  // Reset to active so an input already asserted at reset is no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_active <= 2'h3;
    end else begin
      prev_active <= ext_active;
    end
  end

  // A new edge in the acknowledge cycle keeps the flag set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_pending[0] <= 1'b0;
    end else if (!ext0_cfg.edge_mode) begin
      ext_pending[0] <= ext_active[0];
    end else if (ext_edge[0]) begin
      ext_pending[0] <= 1'b1;
    end else if (ext0_vector_ack) begin
      ext_pending[0] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_pending[1] <= 1'b0;
    end else if (!ext1_cfg.edge_mode) begin
      ext_pending[1] <= ext_active[1];
    end else if (ext_edge[1]) begin
      ext_pending[1] <= 1'b1;
    end else if (ext1_vector_ack) begin
      ext_pending[1] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  iem_req_t src;
  iem_req_t next_irq_req;
  logic     global_irq_enable;
  logic     serial_periph_irq_mask;
  logic     timer2_irq_mask;
  logic     async_serial_irq_mask;
  logic     timer1_irq_mask;
  logic     ext_input1_irq_mask;
  logic     timer0_irq_mask;
  logic     ext_input0_irq_mask;

  assign global_irq_enable      = interrupt_enable_mask_reg[`IEM_GLOBAL_BIT];
  assign serial_periph_irq_mask = interrupt_enable_mask_reg[`IEM_SPI_BIT];
  assign timer2_irq_mask        = interrupt_enable_mask_reg[`IEM_TIMER2_BIT];
  assign async_serial_irq_mask  = interrupt_enable_mask_reg[`IEM_UART_BIT];
  assign timer1_irq_mask        = interrupt_enable_mask_reg[`IEM_TIMER1_BIT];
  assign ext_input1_irq_mask    = interrupt_enable_mask_reg[`IEM_EXT1_BIT];
  assign timer0_irq_mask        = interrupt_enable_mask_reg[`IEM_TIMER0_BIT];
  assign ext_input0_irq_mask    = interrupt_enable_mask_reg[`IEM_EXT0_BIT];

  always_comb begin
    src.spi    = serial_periph_unit_req;
    src.timer2 = timer2_low_overflow_flag | timer2_high_overflow_flag;
    src.uart   = async_serial_port_req;
    src.timer1 = timer1_overflow_flag;
    src.ext1   = ext_pending[1];
    src.timer0 = timer0_overflow_flag;
    src.ext0   = ext_pending[0];
    next_irq_req.spi    = global_irq_enable & serial_periph_irq_mask & src.spi;
    next_irq_req.timer2 = global_irq_enable & timer2_irq_mask & src.timer2;
    next_irq_req.uart   = global_irq_enable & async_serial_irq_mask & src.uart;
    next_irq_req.timer1 = global_irq_enable & timer1_irq_mask & src.timer1;
    next_irq_req.ext1   = global_irq_enable & ext_input1_irq_mask & src.ext1;
    next_irq_req.timer0 = global_irq_enable & timer0_irq_mask & src.timer0;
    next_irq_req.ext0   = global_irq_enable & ext_input0_irq_mask & src.ext0;
  end

  // Global enable low blocks every source; high leaves each individual mask in force
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= next_irq_req;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  global_block_a: assert property (!global_irq_enable |=> irq_req == '0)
    else $error("request passed with global enable low");
  global_pass_a: assert property (global_irq_enable && (src & interrupt_enable_mask_reg[6:0]) != '0
    |=> irq_req != '0)
    else $error("enabled request not passed");
  spi_gate_a: assert property (1'b1 |=> irq_req.spi ==
    $past(global_irq_enable & serial_periph_irq_mask & serial_periph_unit_req))
    else $error("serial peripheral gating wrong");
  timer2_gate_a: assert property (global_irq_enable && timer2_irq_mask
    && timer2_high_overflow_flag |=> irq_req.timer2)
    else $error("timer 2 high flag not passed");
  uart_gate_a: assert property (!async_serial_irq_mask |=> !irq_req.uart)
    else $error("async serial request passed while masked");
  timer1_gate_a: assert property (1'b1 |=> irq_req.timer1 ==
    $past(global_irq_enable & timer1_irq_mask & timer1_overflow_flag))
    else $error("timer 1 gating wrong");
  ext1_gate_a: assert property (1'b1 |=> irq_req.ext1 ==
    $past(global_irq_enable & ext_input1_irq_mask & ext_pending[1]))
    else $error("external 1 gating wrong");
  timer0_gate_a: assert property (1'b1 |=> irq_req.timer0 ==
    $past(global_irq_enable & timer0_irq_mask & timer0_overflow_flag))
    else $error("timer 0 gating wrong");
  ext0_gate_a: assert property (!ext_input0_irq_mask |=> !irq_req.ext0)
    else $error("external 0 request passed while masked");
  byte_write_a: assert property (sfr_wr && sfr_addr == 8'hA8
    |=> interrupt_enable_mask_reg == $past(sfr_wdata))
    else $error("byte write not stored");
  bit_write_a: assert property (!sfr_wr && bit_wr && bit_addr == 8'hAF
    |=> global_irq_enable == $past(bit_wdata))
    else $error("bit write not stored");
  edge_clear_a: assert property (ext0_cfg.edge_mode && ext0_vector_ack && !ext_edge[0]
    |=> !ext_pending[0])
    else $error("edge pending not cleared on vector");
  level_follow_a: assert property (!ext1_cfg.edge_mode
    |=> ext_pending[1] == $past(ext_active[1]))
    else $error("level pending does not follow input");
  reg_readback_a: assert property (sfr_rd && sfr_addr == 8'hA8 && !sfr_wr && !bit_wr
    |=> sfr_rdata == $past(interrupt_enable_mask_reg))
    else $error("read back differs from register");

  enabled_spi_c: cover property (global_irq_enable ##1 irq_req.spi);
  edge_ack_c:    cover property (ext_pending[0] && ext0_vector_ack ##1 !ext_pending[0]);
  bit_set_c:     cover property (bit_wr && bit_hit ##1 global_irq_enable);

endmodule // iem_ctrl

// ===== common/iem_defs.svh
// Purpose: Addresses, bit positions and reset value of the interrupt enable mask register
// Assumes: 8-bit special-function register space with bit addressing
// Notes:   Included by the package user files only
`ifndef IEM_DEFS_SVH
`define IEM_DEFS_SVH

// ----------------------------------------------------------------
// Register location
// ----------------------------------------------------------------
`define IEM_SFR_ADDR      8'hA8
// Bit addresses of this register run from the byte address upward
`define IEM_BIT_BASE      8'hA8
`define IEM_BIT_LAST      8'hAF
`define IEM_RESET_VALUE   8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IEM_GLOBAL_BIT    7
`define IEM_SPI_BIT       6
`define IEM_TIMER2_BIT    5
`define IEM_UART_BIT      4
`define IEM_TIMER1_BIT    3
`define IEM_EXT1_BIT      2
`define IEM_TIMER0_BIT    1
`define IEM_EXT0_BIT      0

`endif

// ===== common/iem_pkg.sv
// Purpose: Types shared by the interrupt enable mask block and its bench
// Assumes: Seven maskable sources, packed in register bit order 6..0
// Notes:   Field order matches the enable register layout below the global bit
package iem_pkg;

  // Source requests or gated requests, msb = serial peripheral unit
  typedef struct packed {
    logic spi;
    logic timer2;
    logic uart;
    logic timer1;
    logic ext1;
    logic timer0;
    logic ext0;
  } iem_req_t;

  // Configuration of one external interrupt input
  typedef struct packed {
    logic edge_mode;   // 1: edge sensitive, 0: level sensitive
    logic active_high; // 1: active high, 0: active low
  } iem_ext_cfg_t;

endpackage

// ===== sim/iem_src_model.sv
// Purpose: Behavioural model of the on-chip request sources feeding the block
// Assumes: The bench changes src_on only at the falling edge of clk
// Notes:   Timer 2 request shows on the flag chosen by t2_hi
`timescale 1ns/1ps
module iem_src_model (
  input  iem_pkg::iem_req_t     src_on,
  input  wire logic             t2_hi,
  input  iem_pkg::iem_ext_cfg_t ext0_cfg,
  input  iem_pkg::iem_ext_cfg_t ext1_cfg,
  output logic                  spi_req,
  output logic                  t2_low,
  output logic                  t2_high,
  output logic                  uart_req,
  output logic                  t1_flag,
  output logic                  t0_flag,
  output logic                  ext0_pin,
  output logic                  ext1_pin
);
  import iem_pkg::*;

  assign spi_req  = src_on.spi;
  assign t2_low   = src_on.timer2 & ~t2_hi;
  assign t2_high  = src_on.timer2 & t2_hi;
  assign uart_req = src_on.uart;
  assign t1_flag  = src_on.timer1;
  assign t0_flag  = src_on.timer0;
  // Active means the selected polarity, so an active-low input sits at 0
  assign ext0_pin = src_on.ext0 ~^ ext0_cfg.active_high;
  assign ext1_pin = src_on.ext1 ~^ ext1_cfg.active_high;
endmodule // iem_src_model

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the interrupt enable mask block
// Assumes: Inputs change at the falling edge; 8 ns clock
// Notes:   Expected values come from the register layout, never from outputs
`timescale 1ns/1ps
module tb_top;
  import iem_pkg::*;
  logic         clk, rst_n, sfr_wr, sfr_rd, bit_wr, bit_wdata, t2_hi, ack0, ack1;
  logic [7:0]   sfr_addr, sfr_wdata, bit_addr, sfr_rdata;
  logic         spi_r, t2l, t2h, uart_r, t1, t0, x0, x1;
  logic [1:0]   ext_pending;
  iem_req_t     src_on, irq_req;
  iem_ext_cfg_t c0, c1;
  int           error_cnt, checked, cyc;

  iem_src_model u_iem_src_model (.src_on(src_on), .t2_hi(t2_hi), .ext0_cfg(c0),
    .ext1_cfg(c1), .spi_req(spi_r), .t2_low(t2l), .t2_high(t2h), .uart_req(uart_r),
    .t1_flag(t1), .t0_flag(t0), .ext0_pin(x0), .ext1_pin(x1));
  iem_ctrl u_iem_ctrl (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
    .bit_wdata(bit_wdata), .serial_periph_unit_req(spi_r), .timer2_low_overflow_flag(t2l),
    .timer2_high_overflow_flag(t2h), .async_serial_port_req(uart_r),
    .timer1_overflow_flag(t1), .timer0_overflow_flag(t0), .ext_irq_input_0(x0),
    .ext_irq_input_1(x1), .ext0_cfg(c0), .ext1_cfg(c1), .ext0_vector_ack(ack0),
    .ext1_vector_ack(ack1), .sfr_rdata(sfr_rdata), .irq_req(irq_req),
    .ext_pending(ext_pending));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobes drop for a full cycle so back-to-back calls never re-drive in one step
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(negedge clk);
    sfr_wr = 1'h0;
    @(negedge clk);
  endtask

  task automatic bw(logic [7:0] a, logic d);
    bit_addr = a;
    bit_wdata = d;
    bit_wr = 1'h1;
    @(negedge clk);
    bit_wr = 1'h0;
    @(negedge clk);
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'h1;
    @(negedge clk);
    chk("sfr_rdata", exp, sfr_rdata);
    sfr_rd = 1'h0;
    @(negedge clk);
  endtask

  task automatic gate(logic [7:0] m, iem_req_t s);
    wr(8'hA8, m);
    src_on = s;
    repeat (3) @(negedge clk);
    chk("irq_req", {1'h0, m[7] ? m[6:0] & s : 7'h00}, {1'h0, irq_req});
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, sfr_wr, sfr_rd, bit_wr, bit_wdata, t2_hi, ack0, ack1} = 8'h00;
    {sfr_addr, sfr_wdata, bit_addr} = 24'h000000;
    src_on = 7'h00;
    c0 = 2'h1;
    c1 = 2'h0;
    {error_cnt, checked, cyc} = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    rd(8'hA8, 8'h00);
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'hFF);
    wr(8'hA9, 8'h00);
    rd(8'hA9, 8'h00);
    rd(8'hA8, 8'hFF);
    wr(8'hA8, 8'h00);
    for (int n = 0; n < 8; n++) begin
      bw(8'(8'hA8 + n), 1'h1);
      rd(8'hA8, 8'((2 << n) - 1));
    end
    bw(8'hAF, 1'h0);
    rd(8'hA8, 8'h7F);
    gate(8'h7F, 7'h7F);
    for (int i = 0; i < 7; i++) begin
      gate(8'h80 | 8'(1 << i), 7'h7F);
    end
    gate(8'hFF, 7'h55);
    t2_hi = 1'h1;
    gate(8'hA0, 7'h20);
    // Edge mode: pending outlives the pulse until the vector acknowledge
    c0 = 2'h3;
    gate(8'h81, 7'h00);
    src_on = 7'h01;
    @(negedge clk);
    src_on = 7'h00;
    repeat (3) @(negedge clk);
    chk("ext_pending", 8'h01, {6'h00, ext_pending});
    chk("irq_req", 8'h01, {1'h0, irq_req});
    ack0 = 1'h1;
    @(negedge clk);
    ack0 = 1'h0;
    repeat (2) @(negedge clk);
    chk("ext_pending", 8'h00, {6'h00, ext_pending});
    chk("irq_req", 8'h00, {1'h0, irq_req});
    // Active-low edge on input 1; an edge in the acknowledge cycle keeps it pending
    c1 = 2'h2;
    wr(8'hA8, 8'h84);
    src_on = 7'h04;
    @(negedge clk);
    src_on = 7'h00;
    @(negedge clk);
    src_on = 7'h04;
    ack1 = 1'h1;
    @(negedge clk);
    src_on = 7'h00;
    ack1 = 1'h0;
    chk("ext_pending", 8'h02, {6'h00, ext_pending});
    @(negedge clk);
    chk("irq_req", 8'h04, {1'h0, irq_req});
    ack1 = 1'h1;
    @(negedge clk);
    ack1 = 1'h0;
    repeat (2) @(negedge clk);
    chk("ext_pending", 8'h00, {6'h00, ext_pending});
    chk("irq_req", 8'h00, {1'h0, irq_req});
    // A byte write and a bit write in one cycle: the byte write wins
    sfr_addr = 8'hA8;
    sfr_wdata = 8'h21;
    bit_addr = 8'hAF;
    bit_wdata = 1'h1;
    sfr_wr = 1'h1;
    bit_wr = 1'h1;
    @(negedge clk);
    sfr_wr = 1'h0;
    bit_wr = 1'h0;
    @(negedge clk);
    rd(8'hA8, 8'h21);
    // Reset in mid-run with every source active: register, requests and pending flags return to zero
    gate(8'hFF, 7'h7F);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    chk("irq_req", 8'h00, {1'h0, irq_req});
    chk("ext_pending", 8'h00, {6'h00, ext_pending});
    rst_n = 1'h1;
    rd(8'hA8, 8'h00);
    chk("irq_req", 8'h00, {1'h0, irq_req});
    src_on = 7'h00;
    report_and_stop();
  end
endmodule // tb_top
